// >>> rtl/timer_pkg.sv
// Function
// - one to eight channels share 16-bit counter
// - center-align select forces all channels to center PWM
// - count clock: bus, fixed clock or external pin
// - prescaler divides by 1 through 128
// - fixed clock synchronised before advancing counter
// - per-channel request plus overflow request
// - counter holds during background debug mode
// - timer keeps running in wait mode
// - capture copies counter, sets channel flag
// - capture on rising, falling or either edge
// - compare match sets flag, applies pin action
// - compare action low, high, toggle or none
// - edge PWM period is modulo plus one
// - edge PWM polarity; period and duty interrupts
// - edge PWM leading edges at period start
// - center PWM period twice modulo
// - center PWM counts up to modulo, down to zero
// - center PWM active on down match, inactive up
// - modulo zero or all ones runs free
// - counter read has no side effect
// - any counter half write resets counter
// - high-true edge PWM high at zero, low at match
// - no pin drive when edge select or clock off
// - after reset no function enabled
package timer_pkg;

  localparam int CNT_W = 16;
  localparam int PS_W = 3;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNT_HI = 8'h04;
  localparam logic [7:0] OFS_CNT_LO = 8'h08;
  localparam logic [7:0] OFS_MOD_HI = 8'h0C;
  localparam logic [7:0] OFS_MOD_LO = 8'h10;
  localparam logic [7:0] OFS_CH_BASE = 8'h20;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CH_CTRL = 8'h00;
  localparam logic [7:0] OFS_CH_VAL_HI = 8'h04;
  localparam logic [7:0] OFS_CH_VAL_LO = 8'h08;

  localparam int CTRL_PS_LSB = 0;
  localparam int CTRL_CLKS_LSB = 3;
  localparam int CTRL_CENTER_ALIGNED_PWM_MODE_BIT = 5;
  localparam int CTRL_OVIE_BIT = 6;
  localparam int CTRL_OVF_BIT = 7;
  localparam int CH_ELS_LSB = 0;
  localparam int CH_MS_LSB = 2;
  localparam int CH_IE_BIT = 4;
  localparam int CH_FLAG_BIT = 7;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] MOD_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_FULL = 16'hFFFF;
  localparam logic [CNT_W-1:0] VAL_RESET = 16'h0000;

  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_BUS = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT = 2'b11
  } count_clock_select_e;

  typedef struct packed {
    logic [PS_W-1:0] prescale;
    count_clock_select_e count_clock_select;
    logic center_align_select;
    logic overflow_ie;
  } timer_ctrl_s;

  typedef struct packed {
    logic [1:0] edge_level_select;
    logic [1:0] mode_select;
    logic irq_enable;
  } chan_ctrl_s;

  localparam timer_ctrl_s CTRL_RESET = '{prescale: 3'h0, count_clock_select: CLK_OFF,
                                         center_align_select: 1'b0, overflow_ie: 1'b0};
  localparam chan_ctrl_s CH_CTRL_RESET = '{edge_level_select: 2'h0, mode_select: 2'h0,
                                           irq_enable: 1'b0};

endpackage

// >>> rtl/edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule

// >>> rtl/tick_prescaler.sv
`timescale 1ns/1ps
module tick_prescaler #(
  parameter int PS_W = 3
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [PS_W-1:0] prescale,
  output logic tick_out
);
  localparam int DIV_W = (1 << PS_W) - 1;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] mask;
  logic wrap;

  // divide by two to the power of prescale
  assign mask = ~({DIV_W{1'b1}} << prescale);
  assign wrap = &(div_reg | ~mask);
  assign tick_out = tick_in & wrap;

  always_ff @(posedge core_clk) begin
    if (sys_rst || clear) begin
      div_reg <= '0;
    end else if (tick_in) begin
      div_reg <= wrap ? '0 : div_reg + 1'b1;
    end
  end
endmodule

// >>> rtl/multichannel_timer_pwm.sv
`timescale 1ns/1ps
module multichannel_timer_pwm #(
  parameter int NUM_CH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic background_debug_mode,
  input wire logic fixed_clk_in,
  input wire logic external_count_clock,
  input wire logic [NUM_CH-1:0] timer_channel_pin_in,
  output logic [NUM_CH-1:0] timer_channel_pin_out,
  output logic [NUM_CH-1:0] timer_channel_pin_oe,
  output logic [NUM_CH-1:0] channel_irq,
  output logic overflow_irq
);
  localparam int W = timer_pkg::CNT_W;

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_fire;
  logic [7:0] wbyte;

  timer_pkg::timer_ctrl_s ctrl_reg;
  logic ovf_flag_reg;
  logic ovf_irq_reg;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] mod_reg;
  logic dir_down_reg;

  logic fixed_rise;
  logic ext_rise;
  logic src_tick;
  logic pre_tick;
  logic cnt_en;
  logic cnt_wr;
  logic clk_on;
  logic center_aligned_pwm_mode;
  logic [W-1:0] top;
  logic at_top;
  logic period_wrap;
  logic ovf_set;

  logic [NUM_CH*W-1:0] ch_val_bus;
  logic [NUM_CH*8-1:0] ch_stat_bus;

  // avalon slave: one wait cycle, then a single cycle with waitrequest low
  assign wr_fire = avs_write & ~wait_reg & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~((avs_read | avs_write) & wait_reg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read & wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    int i;
    logic [7:0] base;
    i = 0;
    rdata_next = 32'h0000_0000;
    base = 8'h00;
    case (avs_address)
      timer_pkg::OFS_CTRL: begin
        rdata_next[7:0] = {ovf_flag_reg, ctrl_reg.overflow_ie, ctrl_reg.center_align_select,
                           ctrl_reg.count_clock_select, ctrl_reg.prescale};
      end
      timer_pkg::OFS_CNT_HI: rdata_next[7:0] = cnt_reg[15:8];
      timer_pkg::OFS_CNT_LO: rdata_next[7:0] = cnt_reg[7:0];
      timer_pkg::OFS_MOD_HI: rdata_next[7:0] = mod_reg[15:8];
      timer_pkg::OFS_MOD_LO: rdata_next[7:0] = mod_reg[7:0];
      default: begin
        for (i = 0; i < NUM_CH; i++) begin
          base = 8'(timer_pkg::OFS_CH_BASE + i * timer_pkg::OFS_CH_STRIDE);
          if (avs_address == base + timer_pkg::OFS_CH_CTRL) begin
            rdata_next[7:0] = ch_stat_bus[i*8 +: 8];
          end
          if (avs_address == base + timer_pkg::OFS_CH_VAL_HI) begin
            rdata_next[7:0] = ch_val_bus[i*W+8 +: 8];
          end
          if (avs_address == base + timer_pkg::OFS_CH_VAL_LO) begin
            rdata_next[7:0] = ch_val_bus[i*W +: 8];
          end
        end
      end
    endcase
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;

  // module control and modulo
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_reg <= timer_pkg::CTRL_RESET;
    end else if (wr_fire && avs_address == timer_pkg::OFS_CTRL) begin
      ctrl_reg.prescale <= wbyte[timer_pkg::CTRL_PS_LSB +: timer_pkg::PS_W];
      ctrl_reg.count_clock_select <=
        timer_pkg::count_clock_select_e'(wbyte[timer_pkg::CTRL_CLKS_LSB +: 2]);
      ctrl_reg.center_align_select <= wbyte[timer_pkg::CTRL_CENTER_ALIGNED_PWM_MODE_BIT];
      ctrl_reg.overflow_ie <= wbyte[timer_pkg::CTRL_OVIE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mod_reg <= timer_pkg::MOD_RESET;
    end else if (wr_fire && avs_address == timer_pkg::OFS_MOD_HI) begin
      mod_reg[15:8] <= wbyte;
    end else if (wr_fire && avs_address == timer_pkg::OFS_MOD_LO) begin
      mod_reg[7:0] <= wbyte;
    end
  end

  // count clock sources
  edge_sync u_fixed_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .din(fixed_clk_in),
    .level(),
    .rise(fixed_rise),
    .fall()
  );

  // sampled at bus rate, so the pin must run at a quarter of it or slower
  edge_sync u_ext_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .din(external_count_clock),
    .level(),
    .rise(ext_rise),
    .fall()
  );

  always_comb begin
    case (ctrl_reg.count_clock_select)
      timer_pkg::CLK_BUS: src_tick = 1'b1;
      timer_pkg::CLK_FIXED: src_tick = fixed_rise;
      timer_pkg::CLK_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
  end

  assign clk_on = ctrl_reg.count_clock_select != timer_pkg::CLK_OFF;
  assign cnt_wr = wr_fire &&
                  (avs_address == timer_pkg::OFS_CNT_HI || avs_address == timer_pkg::OFS_CNT_LO);

  tick_prescaler #(
    .PS_W(timer_pkg::PS_W)
  ) u_prescaler (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(cnt_wr | ~clk_on),
    .tick_in(src_tick),
    .prescale(ctrl_reg.prescale),
    .tick_out(pre_tick)
  );

  // debug mode freezes the count; wait mode has no effect on it
  assign cnt_en = pre_tick & clk_on & ~background_debug_mode;
  assign center_aligned_pwm_mode = ctrl_reg.center_align_select;
  assign top = (mod_reg == timer_pkg::CNT_RESET || mod_reg == timer_pkg::CNT_FULL) ?
               timer_pkg::CNT_FULL : mod_reg;
  assign at_top = cnt_reg == top;
  assign period_wrap = cnt_en & ~center_aligned_pwm_mode & at_top;
  assign ovf_set = period_wrap | (cnt_en & center_aligned_pwm_mode & ~dir_down_reg & at_top);

  // shared counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_reg <= timer_pkg::CNT_RESET;
      dir_down_reg <= 1'b0;
    end else if (cnt_wr) begin
      cnt_reg <= timer_pkg::CNT_RESET;
      dir_down_reg <= 1'b0;
    end else if (cnt_en) begin
      if (!center_aligned_pwm_mode) begin
        cnt_reg <= at_top ? timer_pkg::CNT_RESET : cnt_reg + 1'b1;
        dir_down_reg <= 1'b0;
      end else if (dir_down_reg) begin
        if (cnt_reg == timer_pkg::CNT_RESET) begin
          dir_down_reg <= 1'b0;
          cnt_reg <= cnt_reg + 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end else if (at_top) begin
        dir_down_reg <= 1'b1;
        cnt_reg <= cnt_reg - 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // overflow flag: write one to clear, a new event wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ovf_flag_reg <= 1'b0;
    end else begin
      ovf_flag_reg <= ovf_set | (ovf_flag_reg &
                      ~(wr_fire && avs_address == timer_pkg::OFS_CTRL &&
                        wbyte[timer_pkg::CTRL_OVF_BIT]));
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ovf_irq_reg <= 1'b0;
    end else begin
      ovf_irq_reg <= ovf_flag_reg & ctrl_reg.overflow_ie;
    end
  end

  assign overflow_irq = ovf_irq_reg;

  // channels
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      localparam logic [7:0] BASE = 8'(timer_pkg::OFS_CH_BASE + g * timer_pkg::OFS_CH_STRIDE);
      timer_pkg::chan_ctrl_s cfg_reg;
      logic [W-1:0] val_reg;
      logic flag_reg;
      logic pin_reg;
      logic oe_reg;
      logic irq_reg;
      logic pin_rise;
      logic pin_fall;
      logic wr_ctrl;
      logic wr_hi;
      logic wr_lo;
      logic els_on;
      logic is_cap;
      logic is_cmp;
      logic is_edge_aligned_pwm_mode;
      logic match;
      logic cap_evt;
      logic flag_set;
      logic drive;

      edge_sync u_pin_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .din(timer_channel_pin_in[g]),
        .level(),
        .rise(pin_rise),
        .fall(pin_fall)
      );

      assign wr_ctrl = wr_fire && avs_address == BASE + timer_pkg::OFS_CH_CTRL;
      assign wr_hi = wr_fire && avs_address == BASE + timer_pkg::OFS_CH_VAL_HI;
      assign wr_lo = wr_fire && avs_address == BASE + timer_pkg::OFS_CH_VAL_LO;
      assign els_on = cfg_reg.edge_level_select != 2'h0;
      assign is_cap = ~center_aligned_pwm_mode & (cfg_reg.mode_select == 2'h0);
      assign is_cmp = ~center_aligned_pwm_mode & (cfg_reg.mode_select == 2'h1);
      assign is_edge_aligned_pwm_mode = ~center_aligned_pwm_mode & cfg_reg.mode_select[1];
      assign match = cnt_en & (cnt_reg == val_reg);
      assign cap_evt = is_cap & ((pin_rise & cfg_reg.edge_level_select[0]) |
                                 (pin_fall & cfg_reg.edge_level_select[1]));
      assign flag_set = cap_evt | (match & ~is_cap & (is_cmp | els_on));
      assign drive = els_on & clk_on & ~is_cap;

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          cfg_reg <= timer_pkg::CH_CTRL_RESET;
        end else if (wr_ctrl) begin
          cfg_reg.edge_level_select <= wbyte[timer_pkg::CH_ELS_LSB +: 2];
          cfg_reg.mode_select <= wbyte[timer_pkg::CH_MS_LSB +: 2];
          cfg_reg.irq_enable <= wbyte[timer_pkg::CH_IE_BIT];
        end
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          val_reg <= timer_pkg::VAL_RESET;
        end else if (cap_evt) begin
          val_reg <= cnt_reg;
        end else if (wr_hi) begin
          val_reg[15:8] <= wbyte;
        end else if (wr_lo) begin
          val_reg[7:0] <= wbyte;
        end
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          flag_reg <= 1'b0;
        end else begin
          flag_reg <= flag_set | (flag_reg & ~(wr_ctrl & wbyte[timer_pkg::CH_FLAG_BIT]));
        end
      end

      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          irq_reg <= 1'b0;
        end else begin
          irq_reg <= flag_reg & cfg_reg.irq_enable;
        end
      end

      // pin drive; output level is kept when a mode is entered
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          pin_reg <= 1'b0;
          oe_reg <= 1'b0;
        end else begin
          oe_reg <= drive;
          if (center_aligned_pwm_mode && els_on && match) begin
            pin_reg <= dir_down_reg ^ cfg_reg.edge_level_select[0];
          end else if (is_edge_aligned_pwm_mode && els_on && match) begin
            pin_reg <= cfg_reg.edge_level_select[0];
          end else if (is_edge_aligned_pwm_mode && els_on && period_wrap) begin
            pin_reg <= ~cfg_reg.edge_level_select[0];
          end else if (is_cmp && match) begin
            case (cfg_reg.edge_level_select)
              2'h1: pin_reg <= ~pin_reg;
              2'h2: pin_reg <= 1'b0;
              2'h3: pin_reg <= 1'b1;
              default: pin_reg <= pin_reg;
            endcase
          end
        end
      end

      assign timer_channel_pin_out[g] = pin_reg;
      assign timer_channel_pin_oe[g] = oe_reg;
      assign channel_irq[g] = irq_reg;
      assign ch_val_bus[g*W +: W] = val_reg;
      assign ch_stat_bus[g*8 +: 8] = {flag_reg, 2'b00, cfg_reg.irq_enable,
                                      cfg_reg.mode_select, cfg_reg.edge_level_select};
    end
  endgenerate
endmodule

// >>> tb/multichannel_timer_pwm_asserts.sv
`timescale 1ns/1ps
module multichannel_timer_pwm_asserts #(
  parameter int NUM_CH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [NUM_CH-1:0] timer_channel_pin_oe,
  input wire logic [NUM_CH-1:0] channel_irq,
  input wire logic overflow_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic req;
  logic ctrl_wr;
  logic [1:0] clk_sel_reg;
  logic ovie_reg;
  assign req = avs_read | avs_write;
  assign ctrl_wr = avs_write & ~avs_waitrequest & avs_byteenable[0]
                   & (avs_address == timer_pkg::OFS_CTRL);
  // shadow of the clock select and overflow enable, as software wrote them
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clk_sel_reg <= 2'h0;
      ovie_reg <= 1'b0;
    end else if (ctrl_wr) begin
      clk_sel_reg <= avs_writedata[4:3];
      ovie_reg <= avs_writedata[6];
    end
  end
  AST_ANSWER: assert property ($rose(req) && avs_waitrequest |-> ##1 !avs_waitrequest)
    else $error("no answer one edge after request");
  AST_NOT_EARLY: assert property ($rose(req) |-> avs_waitrequest)
    else $error("answer came too early");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_IDLE_WAIT: assert property (!req && !$past(req) |-> avs_waitrequest)
    else $error("waitrequest low without request");
  AST_HIGH_ZERO: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  AST_RESET_QUIET: assert property ($fell(sys_rst) |->
      timer_channel_pin_oe == '0 && channel_irq == '0 && !overflow_irq)
    else $error("pin or irq active after reset");
  AST_OE_CLK_OFF: assert property (clk_sel_reg == 2'h0 && $past(clk_sel_reg) == 2'h0
      && $past(clk_sel_reg, 2) == 2'h0 |-> timer_channel_pin_oe == '0)
    else $error("pin driven with clock off");
  AST_OVF_MASK: assert property (!ovie_reg && !$past(ovie_reg) && !$past(ovie_reg, 2)
      |-> !overflow_irq)
    else $error("overflow irq while disabled");
  COV_READ: cover property (avs_read && !avs_waitrequest);
  COV_OVF: cover property ($rose(overflow_irq));
  COV_OE: cover property ($rose(timer_channel_pin_oe[0]));
endmodule
bind multichannel_timer_pwm multichannel_timer_pwm_asserts #(.NUM_CH(NUM_CH)) chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .timer_channel_pin_oe(timer_channel_pin_oe),
  .channel_irq(channel_irq), .overflow_irq(overflow_irq));

// >>> tb/timer_pins_model.sv
`timescale 1ns/1ps
module timer_pins_model #(
  parameter int NUM_CH = 2
) (
  input wire logic core_clk,
  input wire logic [NUM_CH-1:0] pin_out,
  input wire logic [NUM_CH-1:0] pin_oe,
  input wire logic [NUM_CH-1:0] drive,
  input wire logic clk_run,
  output logic [NUM_CH-1:0] pin_level,
  output logic src_clk
);
  logic [1:0] phase;
  initial phase = 2'h0;
  initial src_clk = 1'b0;
  // wire level: the timer where it drives, the far side elsewhere
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & drive);
  // count source at one eighth of core rate, still while stopped
  always @(posedge core_clk) begin
    if (clk_run) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        src_clk <= ~src_clk;
      end
    end
  end
endmodule

// >>> tb/test_multichannel_timer_pwm.sv
`timescale 1ns/1ps
module test_multichannel_timer_pwm;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic dbg = 1'b0;
  logic clk_run = 1'b0;
  logic src_clk;
  logic ovf_irq;
  logic [1:0] drive = 2'h0;
  logic [1:0] pin_level;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] ch_irq;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] q;
  int cyc = 0;
  int err_total = 0;
  int checks_done = 0;
  int hi;
  int per;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  multichannel_timer_pwm #(.NUM_CH(2)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .background_debug_mode(dbg), .fixed_clk_in(src_clk), .external_count_clock(src_clk),
    .timer_channel_pin_in(pin_level), .timer_channel_pin_out(pin_out),
    .timer_channel_pin_oe(pin_oe), .channel_irq(ch_irq), .overflow_irq(ovf_irq));
  timer_pins_model #(.NUM_CH(2)) far (
    .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .drive(drive),
    .clk_run(clk_run), .pin_level(pin_level), .src_clk(src_clk));
  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic bus(input logic [7:0] ad, input logic w, input logic [3:0] be,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= ~w;
    avs_byteenable <= be;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      chk(1'b0, "bus timeout");
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    bus(ad, 1'b1, 4'h1, d, q);
  endtask
  task automatic exp_rd(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e,
                        input string s);
    bus(ad, 1'b0, 4'h0, 8'h00, q);
    chk((q & m) === e, s);
  endtask
  task automatic wait_lvl(input logic v, output int t);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pin_out[0] !== v && n < 100);
    t = cyc;
    if (n >= 100) begin
      chk(1'b0, "pin wait timeout");
      report_and_stop();
    end
  endtask
  task automatic pwm_meas(output int h, output int p);
    int t0;
    int t1;
    int t2;
    wait_lvl(1'b0, t0);
    wait_lvl(1'b1, t0);
    wait_lvl(1'b0, t1);
    wait_lvl(1'b1, t2);
    h = t1 - t0;
    p = t2 - t0;
  endtask
  // tick count over a fixed window, one tick of slack for prescaler phase
  task automatic rate(input logic [1:0] src, input int ps, input int div);
    logic [7:0] d;
    int c0;
    int e;
    wr(8'h00, {3'h0, src, ps[2:0]});
    bus(8'h08, 1'b0, 4'h0, 8'h00, a);
    c0 = cyc;
    repeat (200) @(posedge core_clk);
    bus(8'h08, 1'b0, 4'h0, 8'h00, b);
    e = (cyc - c0) / (div << ps);
    d = b - a;
    chk(int'(d) >= e - 1 && int'(d) <= e + 1, "count rate");
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    chk(1'b0, "run timeout");
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    exp_rd(8'h00, 8'hFF, 8'h00, "ctrl after reset");
    exp_rd(8'h20, 8'hFF, 8'h00, "channel ctrl after reset");
    chk(pin_oe === 2'b00, "pins driven after reset");
    wr(8'h14, 8'h5A);
    exp_rd(8'h14, 8'hFF, 8'h00, "unmapped read");
    bus(8'h10, 1'b1, 4'h0, 8'h33, q);
    exp_rd(8'h10, 8'hFF, 8'h00, "masked write landed");
    for (int p = 0; p < 8; p++) rate(2'b01, p, 1);
    clk_run <= 1'b1;
    rate(2'b10, 0, 8);
    rate(2'b11, 0, 8);
    clk_run <= 1'b0;
    wr(8'h00, 8'h08);
    dbg <= 1'b1;
    bus(8'h08, 1'b0, 4'h0, 8'h00, a);
    repeat (40) @(posedge core_clk);
    exp_rd(8'h08, 8'hFF, a, "count moved in debug");
    dbg <= 1'b0;
    repeat (40) @(posedge core_clk);
    exp_rd(8'h08, 8'hFF, a + 8'h29, "count resumed");
    chk(q !== a, "count stuck after debug");
    wr(8'h04, 8'hA5);
    bus(8'h08, 1'b0, 4'h0, 8'h00, a);
    chk(a === 8'h01, "count not reset by write");
    exp_rd(8'h04, 8'hFF, 8'h00, "high half after reset");
    wr(8'h10, 8'h09);
    wr(8'h28, 8'h03);
    wr(8'h38, 8'h03);
    wr(8'h20, 8'h1A);
    wr(8'h30, 8'h09);
    wr(8'h00, 8'h48);
    pwm_meas(hi, per);
    chk(per === 10, "edge pwm period");
    chk(pin_out[1] === ~pin_out[0], "polarity pair");
    chk(pin_oe === 2'b11, "pwm pins not driven");
    chk(ovf_irq === 1'b1, "no period irq");
    chk(ch_irq === 2'b01, "duty irq wrong");
    wr(8'h00, 8'h08);
    repeat (2) @(posedge core_clk);
    chk(ovf_irq === 1'b0, "masked irq");
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h80);
    exp_rd(8'h00, 8'h80, 8'h00, "flag not cleared");
    wr(8'h10, 8'h08);
    wr(8'h28, 8'h05);
    wr(8'h30, 8'h02);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h28);
    pwm_meas(hi, per);
    chk(per === 16, "center period");
    chk(hi === 10, "center duty");
    chk(pin_oe[1] === 1'b1, "center not on all channels");
    wr(8'h00, 8'h08);
    wr(8'h04, 8'h00);
    for (int e = 2; e < 4; e++) begin
      wr(8'h20, {6'h21, e[1:0]});
      repeat (12) @(posedge core_clk);
      chk(pin_out[0] === e[0], "compare set or clear");
    end
    wr(8'h20, 8'h85);
    repeat (12) @(posedge core_clk);
    a[0] = pin_out[0];
    repeat (9) @(posedge core_clk);
    chk(pin_out[0] === ~a[0], "compare toggle");
    wr(8'h20, 8'h84);
    repeat (12) @(posedge core_clk);
    exp_rd(8'h20, 8'h80, 8'h80, "software compare flag");
    chk(pin_oe[0] === 1'b0, "pin driven with no action");
    wr(8'h10, 8'h00);
    wr(8'h30, 8'h81);
    bus(8'h08, 1'b0, 4'h0, 8'h00, a);
    drive[1] <= 1'b1;
    repeat (8) @(posedge core_clk);
    bus(8'h08, 1'b0, 4'h0, 8'h00, b);
    exp_rd(8'h38, 8'hFF, a + 8'h04, "capture value read");
    chk(q - a <= b - a, "capture value");
    exp_rd(8'h30, 8'h80, 8'h80, "capture flag");
    for (int i = 2; i < 8; i++) begin
      wr(8'h30, {6'h20, i[2:1]});
      drive[1] <= i[0];
      repeat (8) @(posedge core_clk);
      exp_rd(8'h30, 8'h80, {i[0] ? i[1] : i[2], 7'h0}, "capture edge select");
    end
    report_and_stop();
  end
endmodule
